// ---- acm_pkg.sv ----
// shared constants and carrier types for the control-mode configuration block
package acm_pkg;

    // ------------------------------------------------------------
    // serial write frame
    // ------------------------------------------------------------
    localparam int          FRAME_BITS  = 32;
    localparam logic [4:0]  FRAME_LAST  = 5'h1f;
    localparam logic [11:0] FRAME_HDR   = 12'h001;
    localparam int          HDR_MSB     = 31;
    localparam int          HDR_LSB     = 20;
    localparam int          ADDR_MSB    = 19;
    localparam int          ADDR_LSB    = 16;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_OUTPUT_CONFIG      = 4'h1;
    localparam logic [3:0] ADDR_CHAN_I_OFFSET      = 4'h2;
    localparam logic [3:0] ADDR_CHAN_I_RANGE       = 4'h3;
    localparam logic [3:0] ADDR_EXTENDED_CONFIG    = 4'h9;
    localparam logic [3:0] ADDR_CHAN_Q_OFFSET      = 4'ha;
    localparam logic [3:0] ADDR_CHAN_Q_RANGE       = 4'hb;
    localparam logic [3:0] ADDR_SAMPLE_PHASE_FINE  = 4'he;
    localparam logic [3:0] ADDR_SAMPLE_PHASE_CMID  = 4'hf;

    // ------------------------------------------------------------
    // power-on register values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_OUTPUT_CONFIG   = 16'hb2ff;
    localparam logic [15:0] RST_OFFSET          = 16'h007f;
    localparam logic [15:0] RST_RANGE           = 16'h807f;
    localparam logic [15:0] RST_EXTENDED_CONFIG = 16'h0000;
    localparam logic [15:0] RST_PHASE_FINE      = 16'h0000;
    localparam logic [15:0] RST_PHASE_CMID      = 16'h0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SECOND_CLOCK_SELECT_N_POS    = 13;
    localparam int DOUBLE_RATE_CLOCK_PHASE_POS  = 11;
    localparam int DOUBLE_RATE_DISABLE_POS      = 10;
    localparam int OUTPUT_SWING_POS             = 9;
    localparam int OUTPUT_EDGE_DEMUX_POS        = 8;
    localparam int PATTERN_OUTPUT_POS           = 15;
    localparam int TRIM_DISABLE_POS             = 14;
    localparam int INTERLEAVE_ENABLE_POS        = 13;
    localparam int ADJ_MSB                      = 15;
    localparam int ADJ_LSB                      = 7;
    localparam int FINE_LSB                     = 8;

    // ------------------------------------------------------------
    // strap handling
    // ------------------------------------------------------------
    localparam logic [1:0] LOCK_DELAY = 2'h2;
    localparam int         TRI_PINS   = 5;
    localparam int         PIN_MODE_PRI  = 0;
    localparam int         PIN_MODE_SEC  = 1;
    localparam int         PIN_RANGE     = 2;
    localparam int         PIN_EDGE_RATE = 3;
    localparam int         PIN_CAL_DLY   = 4;

    typedef enum logic [2:0] {
        ACM_LVL_LOW  = 3'b001,
        ACM_LVL_HIGH = 3'b010,
        ACM_LVL_MID  = 3'b100
    } acm_level_t;

    // settings handed to the converter core
    typedef struct packed {
        logic       ext_mode;
        logic       double_rate;
        logic       clock_phase_90;
        logic       data_edge_rising;
        logic       demux_1to2;
        logic       swing_normal;
        logic       cal_delay_long;
        logic       range_reduced;
        logic [8:0] range_i;
        logic [8:0] range_q;
        logic [8:0] offset_i;
        logic [8:0] offset_q;
        logic       interleave;
        logic       pattern_out;
        logic       clock_continuous;
        logic       second_clock;
        logic [8:0] phase_coarse_mid;
        logic [7:0] phase_fine;
    } acm_settings_t;

    // one accepted serial write
    typedef struct packed {
        logic        valid;
        logic [3:0]  addr;
        logic [15:0] data;
    } acm_write_t;

endpackage

// ---- acm_tri_level.sv ----
// decodes three-level strap pins from their two comparator outputs
`timescale 1ns/1ps
module acm_tri_level
    import acm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic [TRI_PINS-1:0]   above_high,
    input  wire logic [TRI_PINS-1:0]   below_low,
    output acm_level_t                 level [TRI_PINS]
);

    acm_level_t state      [TRI_PINS];
    acm_level_t next_state [TRI_PINS];

    genvar g;
    generate
        for (g = 0; g < TRI_PINS; g++) begin : g_pin
            // neither comparator tripped means floating or half supply
            always_comb begin
                if (above_high[g]) begin
                    next_state[g] = ACM_LVL_HIGH;
                end else if (below_low[g]) begin
                    next_state[g] = ACM_LVL_LOW;
                end else begin
                    next_state[g] = ACM_LVL_MID;
                end
            end
            always_ff @(posedge clk) begin
                if (srst) begin
                    state[g] <= ACM_LVL_MID;
                end else begin
                    state[g] <= next_state[g];
                end
            end
            assign level[g] = state[g];
        end
    endgenerate

endmodule

// ---- acm_serial_port.sv ----
// three-wire write-only serial port, sampled on the system clock
`timescale 1ns/1ps
module acm_serial_port
    import acm_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  srst,
    input  wire logic  enable,
    input  wire logic  ser_clk,
    input  wire logic  ser_data,
    input  wire logic  ser_sel_n,
    output acm_write_t wr
);

    typedef struct packed {
        logic                  clk_prev;
        logic [4:0]            count;
        logic [FRAME_BITS-1:0] shift;
        acm_write_t            wr;
    } acm_sp_state_t;

    acm_sp_state_t state;
    acm_sp_state_t next_state;

    logic [FRAME_BITS-1:0] frame;

    always_comb begin
        next_state          = state;
        next_state.clk_prev = ser_clk;
        next_state.wr.valid = 1'b0;
        frame               = {state.shift[FRAME_BITS-2:0], ser_data};
        if (!enable || ser_sel_n) begin
            next_state.count = 5'h00;
        end else if (ser_clk && !state.clk_prev) begin
            next_state.shift = frame;
            next_state.count = state.count + 5'h01;
            // frames may follow back to back; the count wraps to start the next
            if (state.count == FRAME_LAST && frame[HDR_MSB:HDR_LSB] == FRAME_HDR) begin
                next_state.wr.valid = 1'b1;
                next_state.wr.addr  = frame[ADDR_MSB:ADDR_LSB];
                next_state.wr.data  = frame[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wr = state.wr;

endmodule

// ---- acm_mode_config.sv ----
// control-mode selection and configuration register bank
`timescale 1ns/1ps

// Notes on behaviour
// - primary mode strap low selects register-driven control.
// - primary floating, secondary not low, range pin mid also selects registers.
// - rate chosen by config bit 10, or by edge/rate pin in pin mode.
// - double-rate phase fixed 0 degrees in pin mode and with bit 8 set (non-demux), bit 11 otherwise.
// - pin mode single rate: edge pin high rising, low falling.
// - register mode single rate: bit 8 picks data edge.
// - pin mode swing pin high normal, low reduced amplitude.
// - register mode swing from config bit 9.
// - calibration delay pin picks short or long; register mode short only.
// - pin mode range pin high normal, low reduced, both channels.
// - register mode per-channel range from bits 15:7 at 3h and Bh.
// - offset only in register mode, bits 15:7 at 2h and Ah.
// - pin mode interleave when calibration pin mid; first channel only.
// - register mode interleave from extended bit 13.
// - extended bit 15 set gives test pattern, register mode only.
// - trim disable bit gives continuous output clock, register mode only.
// - register double-rate: bit 8 one non-demux, zero 1:2 demux.
// - config bit 13 zero turns out-of-range pair into second clock.
// - register mode sampling phase from Fh bits 15:7, Eh bits 15:8.
// - reset defaults: double rate, 0 degrees, normal swing, 1:2, range outputs.
// - reset defaults: short delay, normal range, no offset, features off.
// - register contents ignored in pin-driven mode.
// - registers write-only, serial port enabled only in register mode.
module acm_mode_config
    import acm_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [TRI_PINS-1:0] strap_above_high,
    input  wire logic [TRI_PINS-1:0] strap_below_low,
    input  wire logic                swing_pin,
    input  wire logic                ser_clk,
    input  wire logic                ser_data,
    input  wire logic                ser_sel_n,
    output acm_settings_t            settings
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic          locked;
        logic [1:0]    settle;
        logic          ext_mode;
        logic [15:0]   output_config;
        logic [15:0]   chan_i_offset_adjust;
        logic [15:0]   chan_i_range_adjust;
        logic [15:0]   extended_config;
        logic [15:0]   chan_q_offset_adjust;
        logic [15:0]   chan_q_range_adjust;
        logic [15:0]   sample_phase_fine;
        logic [15:0]   sample_phase_coarse_mid;
        acm_settings_t settings;
    } acm_state_t;

    acm_state_t state;
    acm_state_t next_state;

    acm_level_t level [TRI_PINS];
    acm_write_t wr;
    logic       port_enable;

    // ------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------
    // three-level decode
    acm_tri_level u_tri (
        .clk        (clk),
        .srst       (srst),
        .above_high (strap_above_high),
        .below_low  (strap_below_low),
        .level      (level)
    );

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    // port only in register mode
    assign port_enable = state.locked && state.ext_mode;

    acm_serial_port u_port (
        .clk       (clk),
        .srst      (srst),
        .enable    (port_enable),
        .ser_clk   (ser_clk),
        .ser_data  (ser_data),
        .ser_sel_n (ser_sel_n),
        .wr        (wr)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic          mode_req;
    logic          cfg_ddr;
    logic          cfg_nodemux;
    logic [15:0]   oc;
    logic [15:0]   xc;
    acm_settings_t s;

    always_comb begin
        next_state  = state;
        mode_req    = 1'b0;
        oc          = state.output_config;
        xc          = state.extended_config;
        cfg_ddr     = 1'b0;
        cfg_nodemux = 1'b0;
        s           = state.settings;

        // the mode straps are caught once after reset settles, then held; the
        // host must not move them while running, so no re-sampling
        // primary strap low
        if (level[PIN_MODE_PRI] == ACM_LVL_LOW) begin
            mode_req = 1'b1;
        end
        if (level[PIN_MODE_PRI] == ACM_LVL_MID && level[PIN_MODE_SEC] != ACM_LVL_LOW
            && level[PIN_RANGE] == ACM_LVL_MID) begin
            mode_req = 1'b1;
        end
        if (!state.locked) begin
            next_state.settle = state.settle + 2'h1;
            if (state.settle == LOCK_DELAY) begin
                next_state.locked   = 1'b1;
                next_state.ext_mode = mode_req;
            end
        end

        if (wr.valid) begin
            unique case (wr.addr)
                ADDR_OUTPUT_CONFIG: begin
                    next_state.output_config = wr.data;
                end
                ADDR_CHAN_I_OFFSET: begin
                    next_state.chan_i_offset_adjust = wr.data;
                end
                ADDR_CHAN_I_RANGE: begin
                    next_state.chan_i_range_adjust = wr.data;
                end
                ADDR_EXTENDED_CONFIG: begin
                    next_state.extended_config = wr.data;
                end
                ADDR_CHAN_Q_OFFSET: begin
                    next_state.chan_q_offset_adjust = wr.data;
                end
                ADDR_CHAN_Q_RANGE: begin
                    next_state.chan_q_range_adjust = wr.data;
                end
                ADDR_SAMPLE_PHASE_FINE: begin
                    next_state.sample_phase_fine = wr.data;
                end
                ADDR_SAMPLE_PHASE_CMID: begin
                    next_state.sample_phase_coarse_mid = wr.data;
                end
                // calibration and reserved addresses are not held here
                default: begin
                end
            endcase
        end

        s.ext_mode = state.ext_mode;
        if (state.ext_mode) begin
            cfg_ddr     = !oc[DOUBLE_RATE_DISABLE_POS];
            cfg_nodemux = oc[OUTPUT_EDGE_DEMUX_POS];
            s.double_rate = cfg_ddr;
            // phase bit, 0 degrees forced when not demultiplexed
            s.clock_phase_90 = cfg_ddr && !cfg_nodemux && oc[DOUBLE_RATE_CLOCK_PHASE_POS];
            s.data_edge_rising = oc[OUTPUT_EDGE_DEMUX_POS];
            // demux choice shares the edge bit
            s.demux_1to2 = !(cfg_ddr && cfg_nodemux);
            s.swing_normal = oc[OUTPUT_SWING_POS];
            s.cal_delay_long = 1'b0;
            s.range_reduced  = 1'b0;
            s.range_i = state.chan_i_range_adjust[ADJ_MSB:ADJ_LSB];
            s.range_q = state.chan_q_range_adjust[ADJ_MSB:ADJ_LSB];
            s.offset_i = state.chan_i_offset_adjust[ADJ_MSB:ADJ_LSB];
            s.offset_q = state.chan_q_offset_adjust[ADJ_MSB:ADJ_LSB];
            s.interleave = xc[INTERLEAVE_ENABLE_POS];
            s.pattern_out = xc[PATTERN_OUTPUT_POS];
            s.clock_continuous = xc[TRIM_DISABLE_POS];
            s.second_clock = !oc[SECOND_CLOCK_SELECT_N_POS];
            s.phase_coarse_mid = state.sample_phase_coarse_mid[ADJ_MSB:ADJ_LSB];
            s.phase_fine       = state.sample_phase_fine[ADJ_MSB:FINE_LSB];
        end else begin
            // rate from edge/rate pin, mid means double rate
            s.double_rate = (level[PIN_EDGE_RATE] == ACM_LVL_MID);
            s.clock_phase_90 = 1'b0;
            s.data_edge_rising = (level[PIN_EDGE_RATE] == ACM_LVL_HIGH);
            s.demux_1to2       = 1'b1;
            s.swing_normal = swing_pin;
            s.cal_delay_long = (level[PIN_CAL_DLY] == ACM_LVL_HIGH);
            s.range_reduced = (level[PIN_RANGE] == ACM_LVL_LOW);
            s.range_i       = RST_RANGE[ADJ_MSB:ADJ_LSB];
            s.range_q       = RST_RANGE[ADJ_MSB:ADJ_LSB];
            s.offset_i = RST_OFFSET[ADJ_MSB:ADJ_LSB];
            s.offset_q = RST_OFFSET[ADJ_MSB:ADJ_LSB];
            // interleave from mid calibration pin, first channel feeds both
            s.interleave       = (level[PIN_CAL_DLY] == ACM_LVL_MID);
            s.pattern_out      = 1'b0;
            s.clock_continuous = 1'b0;
            s.second_clock     = 1'b0;
            s.phase_coarse_mid = RST_PHASE_CMID[ADJ_MSB:ADJ_LSB];
            s.phase_fine       = RST_PHASE_FINE[ADJ_MSB:FINE_LSB];
        end
        // settings only go live once the mode is locked
        if (state.locked) begin
            next_state.settings = s;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state.locked   <= 1'b0;
            state.settle   <= 2'h0;
            state.ext_mode <= 1'b0;
            state.output_config <= RST_OUTPUT_CONFIG;
            state.chan_i_offset_adjust    <= RST_OFFSET;
            state.chan_i_range_adjust     <= RST_RANGE;
            state.extended_config         <= RST_EXTENDED_CONFIG;
            state.chan_q_offset_adjust    <= RST_OFFSET;
            state.chan_q_range_adjust     <= RST_RANGE;
            state.sample_phase_fine       <= RST_PHASE_FINE;
            state.sample_phase_coarse_mid <= RST_PHASE_CMID;
            state.settings.ext_mode         <= 1'b0;
            state.settings.double_rate      <= 1'b1;
            state.settings.clock_phase_90   <= 1'b0;
            state.settings.data_edge_rising <= 1'b0;
            state.settings.demux_1to2       <= 1'b1;
            state.settings.swing_normal     <= 1'b1;
            state.settings.cal_delay_long   <= 1'b0;
            state.settings.range_reduced    <= 1'b0;
            state.settings.range_i          <= RST_RANGE[ADJ_MSB:ADJ_LSB];
            state.settings.range_q          <= RST_RANGE[ADJ_MSB:ADJ_LSB];
            state.settings.offset_i         <= RST_OFFSET[ADJ_MSB:ADJ_LSB];
            state.settings.offset_q         <= RST_OFFSET[ADJ_MSB:ADJ_LSB];
            state.settings.interleave       <= 1'b0;
            state.settings.pattern_out      <= 1'b0;
            state.settings.clock_continuous <= 1'b0;
            state.settings.second_clock     <= 1'b0;
            state.settings.phase_coarse_mid <= RST_PHASE_CMID[ADJ_MSB:ADJ_LSB];
            state.settings.phase_fine       <= RST_PHASE_FINE[ADJ_MSB:FINE_LSB];
        end else begin
            state <= next_state;
        end
    end

    assign settings = state.settings;

endmodule

// ---- acm_mode_config_properties.sv ----
// port checks for the control-mode configuration block
`timescale 1ns/1ps
module acm_mode_config_properties
    import acm_pkg::*;
(
    input wire logic          clk,
    input wire logic          srst,
    input wire logic          swing_pin,
    input wire acm_settings_t settings
);
    logic [2:0] age;
    always_ff @(posedge clk) begin
        if (srst)
            age <= 3'h0;
        else if (age != 3'h7)
            age <= age + 3'h1;
    end
    // mode lock takes a few edges, so running checks wait for it
    wire logic old = (age == 3'h7);
    wire logic pin = old && !settings.ext_mode;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_RESET_DEFAULTS: assert property ($fell(srst) |-> settings.double_rate
        && settings.swing_normal && settings.demux_1to2 && settings.offset_i == 9'h0)
        else $error("reset defaults wrong");
    AST_PIN_FEATURES_OFF: assert property (pin |-> !settings.pattern_out
        && !settings.second_clock && !settings.clock_continuous && settings.offset_q == 9'h0)
        else $error("register feature active in pin mode");
    AST_PIN_PHASE0: assert property (!settings.ext_mode && settings.double_rate
        |-> !settings.clock_phase_90) else $error("pin mode phase not zero");
    AST_NONDEMUX_PHASE: assert property (settings.double_rate && !settings.demux_1to2
        |-> !settings.clock_phase_90) else $error("non-demux phase not zero");
    AST_EXT_SHORT_DELAY: assert property (settings.ext_mode |-> !settings.cal_delay_long)
        else $error("long delay in register mode");
    AST_MODE_LOCKED: assert property (old |-> $stable(settings.ext_mode))
        else $error("mode changed while running");
    AST_PIN_SWING: assert property (pin && $stable(swing_pin)
        && swing_pin == $past(swing_pin, 2) |-> settings.swing_normal == swing_pin)
        else $error("swing does not follow pin");
    AST_SWING_RISE: assert property (pin && $rose(swing_pin) |-> ##[1:3] settings.swing_normal)
        else $error("swing pin rise not seen");
endmodule

// ---- acm_host_model.sv ----
// host model: strap levels and three-wire register writes
`timescale 1ns/1ps
module acm_host_model
    import acm_pkg::*;
(
    input  wire logic           clk,
    output logic [TRI_PINS-1:0] strap_above_high,
    output logic [TRI_PINS-1:0] strap_below_low,
    output logic                swing_pin,
    output logic                ser_clk,
    output logic                ser_data,
    output logic                ser_sel_n
);
    initial begin
        strap_above_high = 5'h1e;
        strap_below_low = 5'h01;
        swing_pin = 1'b1;
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_sel_n = 1'b1;
    end
    // mode straps are set under reset by the caller; t_pin_mode also moves the range pin while running
    task automatic set_pin(input int idx, input logic [1:0] lvl);
        strap_above_high[idx] = (lvl == 2'h1);
        strap_below_low[idx] = (lvl == 2'h0);
    endtask
    // 32 bits msb first, data held while the serial clock is high
    task automatic send_frame(input logic [31:0] f, input logic hold_sel);
        ser_sel_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            ser_data = f[i];
            repeat (2) @(posedge clk);
            #1 ser_clk = 1'b1;
            repeat (2) @(posedge clk);
            #1 ser_clk = 1'b0;
        end
        ser_sel_n = hold_sel ? 1'b0 : 1'b1;
        // released line: show the inverse, not a stale copy
        if (!hold_sel)
            ser_data = ~ser_data;
    endtask
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d, input logic hold_sel);
        send_frame({FRAME_HDR, a, d}, hold_sel);
    endtask
endmodule

// ---- acm_mode_config_tb.sv ----
// self-checking bench for the control-mode configuration block
`timescale 1ns/1ps
module acm_mode_config_tb
    import acm_pkg::*;
;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    logic [TRI_PINS-1:0] strap_above_high;
    logic [TRI_PINS-1:0] strap_below_low;
    logic                swing_pin, ser_clk, ser_data, ser_sel_n;
    acm_settings_t       settings, exp;
    int                  miscompares = 0;
    int                  tests_run = 0;
    logic [15:0]         cfg [3] = '{16'hb7ff, 16'hb6ff, 16'hb9ff};
    logic [3:0]          cfg_exp [3] = '{4'b0101, 4'b0101, 4'b1000};
    logic [1:0]          sec_lvl [3] = '{2'h1, 2'h2, 2'h0};
    always #12.5 clk = ~clk;
    acm_host_model host_u (.clk(clk), .strap_above_high(strap_above_high),
        .strap_below_low(strap_below_low), .swing_pin(swing_pin), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_sel_n(ser_sel_n));
    acm_mode_config dut_u (.clk(clk), .srst(srst), .strap_above_high(strap_above_high),
        .strap_below_low(strap_below_low), .swing_pin(swing_pin), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_sel_n(ser_sel_n), .settings(settings));
    function automatic bit ok(input bit c);
        tests_run++;
        return c;
    endfunction
    task automatic bad(input string m);
        miscompares++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] pri, input logic [1:0] sec, input logic [1:0] rng);
        srst = 1'b1;
        host_u.set_pin(PIN_MODE_PRI, pri);
        host_u.set_pin(PIN_MODE_SEC, sec);
        host_u.set_pin(PIN_RANGE, rng);
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    function automatic acm_settings_t defaults(input logic ext);
        acm_settings_t s;
        s = '0;
        s.ext_mode = ext;
        s.double_rate = 1'b1;
        s.demux_1to2 = 1'b1;
        s.swing_normal = 1'b1;
        s.range_i = 9'h100;
        s.range_q = 9'h100;
        return s;
    endfunction
    task automatic t_ext_regs();
        do_reset(2'h0, 2'h1, 2'h1);
        if (!ok(settings === defaults(1'b1))) bad("register mode defaults");
        host_u.write_reg(ADDR_OUTPUT_CONFIG, 16'h88ff, 1'b1);
        host_u.write_reg(ADDR_CHAN_I_RANGE, {9'h1a5, 7'h7f}, 1'b1);
        host_u.write_reg(ADDR_CHAN_Q_RANGE, {9'h05a, 7'h7f}, 1'b1);
        host_u.write_reg(ADDR_CHAN_I_OFFSET, {9'h0c3, 7'h7f}, 1'b1);
        host_u.write_reg(ADDR_CHAN_Q_OFFSET, {9'h13c, 7'h7f}, 1'b1);
        host_u.write_reg(ADDR_EXTENDED_CONFIG, 16'he000, 1'b1);
        host_u.write_reg(ADDR_SAMPLE_PHASE_FINE, 16'ha5ff, 1'b1);
        host_u.write_reg(ADDR_SAMPLE_PHASE_CMID, {9'h155, 7'h7f}, 1'b1);
        host_u.send_frame({12'h002, ADDR_OUTPUT_CONFIG, 16'hb7ff}, 1'b1);
        host_u.write_reg(4'h4, 16'hb7ff, 1'b0);
        settle();
        exp = defaults(1'b1);
        exp.clock_phase_90 = 1'b1;
        exp.swing_normal = 1'b0;
        exp.second_clock = 1'b1;
        {exp.range_i, exp.range_q, exp.offset_i, exp.offset_q} = {9'h1a5, 9'h05a, 9'h0c3, 9'h13c};
        {exp.pattern_out, exp.clock_continuous, exp.interleave} = 3'b111;
        {exp.phase_fine, exp.phase_coarse_mid} = {8'ha5, 9'h155};
        if (!ok(settings === exp)) bad("register fields");
        for (int i = 0; i < 3; i++) begin
            host_u.write_reg(ADDR_OUTPUT_CONFIG, cfg[i], 1'b0);
            settle();
            if (!ok({settings.double_rate, settings.demux_1to2, settings.clock_phase_90,
                settings.swing_normal} === cfg_exp[i])) bad("clocking fields");
            if (i < 2 && !ok(settings.data_edge_rising === cfg[i][8])) bad("sdr edge");
        end
        $display("test ext_regs done");
    endtask
    task automatic t_pin_mode();
        host_u.set_pin(PIN_EDGE_RATE, 2'h1);
        host_u.set_pin(PIN_CAL_DLY, 2'h1);
        host_u.swing_pin = 1'b0;
        do_reset(2'h1, 2'h1, 2'h0);
        host_u.write_reg(ADDR_EXTENDED_CONFIG, 16'he000, 1'b0);
        settle();
        exp = defaults(1'b0);
        {exp.double_rate, exp.data_edge_rising, exp.swing_normal} = 3'b010;
        {exp.cal_delay_long, exp.range_reduced} = 2'b11;
        if (!ok(settings === exp)) bad("pin mode settings");
        host_u.set_pin(PIN_EDGE_RATE, 2'h0);
        host_u.set_pin(PIN_CAL_DLY, 2'h2);
        host_u.set_pin(PIN_RANGE, 2'h1);
        host_u.swing_pin = 1'b1;
        settle();
        {exp.data_edge_rising, exp.swing_normal, exp.cal_delay_long} = 3'b010;
        {exp.range_reduced, exp.interleave} = 2'b01;
        if (!ok(settings === exp)) bad("pin changes");
        host_u.set_pin(PIN_EDGE_RATE, 2'h2);
        host_u.set_pin(PIN_CAL_DLY, 2'h0);
        settle();
        if (!ok({settings.double_rate, settings.clock_phase_90} === 2'b10)) bad("pin ddr");
        if (!ok({settings.cal_delay_long, settings.interleave} === 2'b00))
            bad("cal pin low");
        $display("test pin_mode done");
    endtask
    task automatic t_alt_mode();
        for (int i = 0; i < 3; i++) begin
            do_reset(2'h2, sec_lvl[i], 2'h2);
            if (!ok(settings.ext_mode === (i < 2))) bad("range pin mode select");
        end
        $display("test alt_mode done");
    endtask
    initial begin
        #1;
        t_ext_regs();
        t_pin_mode();
        t_alt_mode();
        results();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad("run limit reached");
        results();
    end
endmodule
bind acm_mode_config acm_mode_config_properties chk_u (.clk(clk), .srst(srst),
    .swing_pin(swing_pin), .settings(settings));
